// [src/timer_counter.sv]
`timescale 1ns/10ps

module timer_counter
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext_count_input,
    input wire logic clock_source_select,
    input wire logic source_edge_select,
    input wire logic prescaler_bypass,
    input wire logic [2:0] prescale_ratio_select,
    input wire logic width_select,
    input wire logic sleep_active,
    input wire logic low_wr,
    input wire logic high_wr,
    input wire logic [7:0] wr_data,
    input wire logic low_rd,
    input wire logic flag_clear,
    input wire logic overflow_irq_enable,
    output logic [7:0] low_count_byte,
    output logic [7:0] high_byte_buffer,
    output logic overflow_flag,
    output logic irq
);

    logic rst_meta;
    logic rst_n;
    logic ext_edge;
    logic [7:0] count_high;
    logic [7:0] prescale_count;
    logic [1:0] inhibit;
    logic blocked;
    logic src_event;
    logic prescale_hit;
    logic tick;
    logic wrap;

    // ********************************************
    // Divider mask for the selected prescale ratio.
    // ********************************************
    function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
        logic [8:0] span;
        span = 9'h002 << sel;
        return 8'(span - 9'h001);
    endfunction

    // ********************************************
    // Reset release through two flip-flops.
    // ********************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ********************************************
    // External count input synchronizer and edge select.
    // ********************************************
    count_edge_detect edge_detect
    (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ext_count_input),
        .falling_select(source_edge_select),
        .edge_pulse(ext_edge)
    );

    // ********************************************
    // Increment source and gating.
    // ********************************************
    always_comb
    begin
        // The timer needs clock cycles, so it is halted during sleep.
        blocked = low_wr || (inhibit != timer_counter_pkg::INHIBIT_NONE) || sleep_active;
        if (clock_source_select)
        begin
            src_event = ext_edge;
        end
        else
        begin
            src_event = 1'b1;
        end
        // Reaching or passing the mask is a hit, so a lower ratio takes effect at once.
        prescale_hit = (prescale_count >= ratio_mask(prescale_ratio_select));
        if (prescaler_bypass)
        begin
            tick = src_event && !blocked;
        end
        else
        begin
            tick = src_event && !blocked && prescale_hit;
        end
        if (width_select == timer_counter_pkg::WIDTH_8BIT)
        begin
            wrap = tick && (low_count_byte == timer_counter_pkg::COUNT_MAX_8);
        end
        else
        begin
            wrap = tick && ({count_high, low_count_byte} == timer_counter_pkg::COUNT_MAX_16);
        end
    end

    // ********************************************
    // Write inhibit window.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inhibit <= timer_counter_pkg::INHIBIT_NONE;
        end
        else if (low_wr)
        begin
            inhibit <= timer_counter_pkg::INHIBIT_CYCLES;
        end
        else if (inhibit != timer_counter_pkg::INHIBIT_NONE)
        begin
            inhibit <= inhibit - 2'h1;
        end
    end

    // ********************************************
    // Prescaler counter, hidden from software.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_count <= timer_counter_pkg::PRESCALE_RESET;
        end
        else if (low_wr && !prescaler_bypass)
        begin
            prescale_count <= timer_counter_pkg::PRESCALE_RESET;
        end
        else if (!prescaler_bypass && src_event && !blocked)
        begin
            if (prescale_hit)
            begin
                prescale_count <= timer_counter_pkg::PRESCALE_RESET;
            end
            else
            begin
                prescale_count <= prescale_count + 8'h01;
            end
        end
    end

    // ********************************************
    // Low count byte.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_count_byte <= timer_counter_pkg::COUNT_RESET;
        end
        else if (low_wr)
        begin
            low_count_byte <= wr_data;
        end
        else if (tick)
        begin
            low_count_byte <= low_count_byte + 8'h01;
        end
    end

    // ********************************************
    // High count byte, counting only in 16-bit mode.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_high <= timer_counter_pkg::COUNT_RESET;
        end
        else if (low_wr && width_select != timer_counter_pkg::WIDTH_8BIT)
        begin
            count_high <= high_byte_buffer;
        end
        else if (tick && width_select != timer_counter_pkg::WIDTH_8BIT
                 && low_count_byte == timer_counter_pkg::COUNT_MAX_8)
        begin
            count_high <= count_high + 8'h01;
        end
    end

    // ********************************************
    // High byte buffer.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_byte_buffer <= timer_counter_pkg::BUFFER_RESET;
        end
        else if (high_wr)
        begin
            high_byte_buffer <= wr_data;
        end
        else if (low_rd && width_select != timer_counter_pkg::WIDTH_8BIT)
        begin
            high_byte_buffer <= count_high;
        end
    end

    // ********************************************
    // Overflow flag; a wrap in the clearing cycle wins.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_flag <= 1'b0;
        end
        else if (wrap)
        begin
            overflow_flag <= 1'b1;
        end
        else if (flag_clear)
        begin
            overflow_flag <= 1'b0;
        end
    end

    // ********************************************
    // Masked interrupt request.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= overflow_flag && overflow_irq_enable;
        end
    end

    // ********************************************
    // Checks.
    // ********************************************
    a_write_inhibit: assert property (@(posedge clk) disable iff (!rst_n)
        (low_wr ##1 !low_wr [*2]) |-> $stable(low_count_byte) ##1 $stable(low_count_byte))
        else $error("Count advanced inside the write inhibit window.");

    a_timer_increment: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !low_wr) |=> low_count_byte == $past(low_count_byte) + 8'h01)
        else $error("Count did not advance by one on a tick.");

    a_bypass_direct: assert property (@(posedge clk) disable iff (!rst_n)
        (prescaler_bypass && !clock_source_select && !blocked)
        |=> low_count_byte == $past(low_count_byte) + 8'h01)
        else $error("Bypassed timer missed an instruction cycle.");

    a_prescale_ratio: assert property (@(posedge clk) disable iff (!rst_n)
        (!prescaler_bypass && !blocked && prescale_count < ratio_mask(prescale_ratio_select))
        |=> $stable(low_count_byte))
        else $error("Prescaled tick before the selected ratio was reached.");

    a_prescale_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (low_wr && !prescaler_bypass) |=> prescale_count == 8'h00)
        else $error("Count write did not clear the prescaler.");

    a_overflow_set: assert property (@(posedge clk) disable iff (!rst_n)
        wrap |=> overflow_flag && low_count_byte == 8'h00)
        else $error("Wrap did not set the overflow flag.");

    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
        !(overflow_flag && overflow_irq_enable) |=> !irq)
        else $error("Interrupt raised while masked or flag clear.");

    a_snapshot_read: assert property (@(posedge clk) disable iff (!rst_n)
        (low_rd && !high_wr && width_select != timer_counter_pkg::WIDTH_8BIT)
        |=> high_byte_buffer == $past(count_high))
        else $error("Low byte read did not capture the high count.");

    a_load_16bit: assert property (@(posedge clk) disable iff (!rst_n)
        (low_wr && width_select != timer_counter_pkg::WIDTH_8BIT)
        |=> count_high == $past(high_byte_buffer) && low_count_byte == $past(wr_data))
        else $error("Low byte write did not load all sixteen bits.");

    a_sleep_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        (sleep_active && !low_wr) |=> $stable(low_count_byte) && !$rose(overflow_flag))
        else $error("Timer advanced during sleep.");

endmodule

// [src/timer_counter_pkg.sv]
package timer_counter_pkg;

    // Cycles during which incrementing stays suppressed after a count write.
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
    localparam logic [1:0] INHIBIT_NONE = 2'h0;

    // Values after reset.
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    // Width select encoding: set selects 8-bit counting.
    localparam logic WIDTH_8BIT = 1'b1;

    // Wrap points of the count.
    localparam logic [7:0] COUNT_MAX_8 = 8'hFF;
    localparam logic [15:0] COUNT_MAX_16 = 16'hFFFF;

endpackage

// [src/count_edge_detect.sv]
`timescale 1ns/10ps

module count_edge_detect
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic falling_select,
    output logic edge_pulse
);

    logic pin_meta;
    logic pin_sync;
    logic pin_last;

    // ********************************************
    // Two-stage synchronizer to the instruction clock.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end
        else
        begin
            pin_meta <= pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    // ********************************************
    // Edge selection on the synchronized level.
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_pulse <= 1'b0;
        end
        else if (falling_select)
        begin
            edge_pulse <= pin_last & ~pin_sync;
        end
        else
        begin
            edge_pulse <= pin_sync & ~pin_last;
        end
    end

endmodule

// [tb/ext_pulse_src.sv]
`timescale 1ns/10ps

// ****************************************
// External count pulse source
// ****************************************
module ext_pulse_src
(
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] n,
    output logic pin,
    output logic busy
);
    initial
    begin
        pin = 1'b0;
        busy = 1'b0;
    end

    // Each level lasts eight clocks, long enough for the synchronizer.
    always
    begin
        @(posedge clk);
        if (go)
        begin
            busy <= 1'b1;
            repeat (n)
            begin
                pin <= 1'b1;
                repeat (8) @(posedge clk);
                pin <= 1'b0;
                repeat (8) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
endmodule

// [tb/test_timer_counter_with_prescaler.sv]
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

// ****************************************
// Bench
// ****************************************
module test_timer_counter_with_prescaler;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic src = 1'b0, es = 1'b0, byp = 1'b1, wsel = 1'b1, en = 1'b0, slp = 1'b0;
    logic [2:0] ratio = 3'h0;
    logic low_wr = 1'b0, high_wr = 1'b0, low_rd = 1'b0, flag_clear = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic go = 1'b0;
    logic pin, busy, flag, irq;
    logic [7:0] low, buffer;
    int n_fail = 0;
    int n_tests = 0;

    timer_counter dut
    (
        .clk(clk), .arst_n(arst_n), .ext_count_input(pin), .clock_source_select(src),
        .source_edge_select(es), .prescaler_bypass(byp), .prescale_ratio_select(ratio),
        .width_select(wsel), .sleep_active(slp), .low_wr(low_wr), .high_wr(high_wr),
        .wr_data(wr_data), .low_rd(low_rd), .flag_clear(flag_clear),
        .overflow_irq_enable(en), .low_count_byte(low), .high_byte_buffer(buffer),
        .overflow_flag(flag), .irq(irq)
    );

    ext_pulse_src partner
    (
        .clk(clk), .go(go), .n(4'h2), .pin(pin), .busy(busy)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr(input logic hi, input logic [7:0] d);
        @(posedge clk);
        high_wr <= hi;
        low_wr <= ~hi;
        wr_data <= d;
        @(posedge clk);
        high_wr <= 1'b0;
        low_wr <= 1'b0;
    endtask

    task automatic read_low();
        @(posedge clk);
        low_rd <= 1'b1;
        @(posedge clk);
        low_rd <= 1'b0;
    endtask

    task automatic clear_flag();
        @(posedge clk);
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
    endtask

    task automatic set_cfg(input logic s, input logic e, input logic b, input logic [2:0] r,
        input logic w);
        @(posedge clk);
        src <= s;
        es <= e;
        byp <= b;
        ratio <= r;
        wsel <= w;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("wrong value watchdog expected done seen hang");
        give_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        set_cfg(1'b0, 1'b0, 1'b1, 3'h0, 1'b1);
        wr(1'b0, 8'h10);
        tick(0); `CHK("low", 8'h10, low)
        tick(2); `CHK("low", 8'h10, low)
        tick(1); `CHK("low", 8'h11, low)
        tick(10); `CHK("low", 8'h1B, low)
        $display("test timer done");
        for (int n = 0; n < 8; n++)
        begin
            set_cfg(1'b0, 1'b0, 1'b0, n[2:0], 1'b1);
            wr(1'b0, 8'h00);
            tick(1 + (4 << n)); `CHK("low", 8'h01, low)
            tick(1); `CHK("low", 8'h02, low)
        end
        tick(100); `CHK("low", 8'h02, low)
        set_cfg(1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
        tick(1); `CHK("low", 8'h03, low)
        tick(2); `CHK("low", 8'h04, low)
        $display("test prescaler done");
        set_cfg(1'b0, 1'b0, 1'b1, 3'h0, 1'b1);
        wr(1'b0, 8'hF0);
        slp <= 1'b1;
        tick(10); `CHK("low", 8'hF0, low)
        @(posedge clk);
        slp <= 1'b0;
        $display("test sleep done");
        clear_flag();
        wr(1'b0, 8'hFE);
        tick(3); `CHK("flag", 1'b0, flag)
        tick(1); `CHK("low", 8'h00, low)
        `CHK("flag", 1'b1, flag)
        tick(2); `CHK("irq", 1'b0, irq)
        @(posedge clk);
        en <= 1'b1;
        tick(1); `CHK("irq", 1'b1, irq)
        clear_flag();
        tick(0); `CHK("flag", 1'b0, flag)
        tick(1); `CHK("irq", 1'b0, irq)
        @(posedge clk);
        en <= 1'b0;
        $display("test overflow done");
        set_cfg(1'b0, 1'b0, 1'b1, 3'h0, 1'b0);
        wr(1'b1, 8'h12);
        wr(1'b0, 8'hFF);
        clear_flag();
        tick(1); `CHK("low", 8'h00, low)
        `CHK("flag", 1'b0, flag)
        read_low();
        tick(0); `CHK("buffer", 8'h13, buffer)
        wr(1'b1, 8'hFF);
        wr(1'b0, 8'hFF);
        tick(3); `CHK("flag", 1'b1, flag)
        read_low();
        tick(0); `CHK("buffer", 8'h00, buffer)
        $display("test wide done");
        for (int e = 0; e < 2; e++)
        begin
            set_cfg(1'b1, e[0], 1'b1, 3'h0, 1'b1);
            wr(1'b0, 8'h00);
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge pin);
            tick(3); `CHK("low", 8'h00, low)
            tick(2); `CHK("low", {7'h00, ~e[0]}, low)
            wait (!busy);
            tick(6); `CHK("low", 8'h02, low)
        end
        $display("test counter done");
        give_verdict();
    end
endmodule
